// ==== shared/fpm_pkg.sv ====
/*
  shared constants and types of the front panel meter control block.
  assumes a 100 MHz system clock and 16-bit readings in tenths.
*/
package fpm_pkg;

  // key lines, one bit each
  localparam int KEY_N = 12;
  localparam int K_FWD = 0;
  localparam int K_RFL = 1;
  localparam int K_SWR = 2;
  localparam int K_MIN = 3;
  localparam int K_MAX = 4;
  localparam int K_LOG = 5;
  localparam int K_LIGHT = 6;
  localparam int K_AUTO = 7;
  localparam int K_UP = 8;
  localparam int K_DOWN = 9;
  localparam int K_PWR = 10;
  localparam int K_MASTER = 11;

  // display indicator bits
  localparam int IND_W = 8;
  localparam int I_FWD = 0;
  localparam int I_RFL = 1;
  localparam int I_SWR = 2;
  localparam int I_DBM = 3;
  localparam int I_WATT = 4;
  localparam int I_RL = 5;
  localparam int I_AUTO = 6;
  localparam int I_RERR = 7;

  // interrupt events
  localparam int EV_N = 4;
  localparam int E_OVER = 0;
  localparam int E_UNDER = 1;
  localparam int E_BUZZ = 2;
  localparam int E_RERR = 3;

  // timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint BL_MIN = 30;
  localparam longint BL_CYC = BL_MIN * 60 * CLK_HZ;
  localparam longint FLASH_SEC = 30;
  localparam longint FLASH_CYC = FLASH_SEC * CLK_HZ;

  // limit factors (per cent, per mille, tenths)
  localparam logic [11:0] K_ONE_PM = 12'h3e8;
  localparam logic [11:0] K_ONE_PC = 12'h064;
  localparam logic [11:0] K_FS_OVER = 12'h7cf;
  localparam logic [11:0] K_120 = 12'h078;
  localparam logic [11:0] K_3 = 12'h003;
  localparam logic [11:0] K_20 = 12'h014;
  localparam logic [15:0] RL_MAX = 16'h0190;
  localparam logic [15:0] SWR_LO = 16'h000a;
  localparam logic [15:0] SWR_HI = 16'h07cf;

  // register map
  localparam logic [7:0] A_FS_TOP = 8'h00;
  localparam logic [7:0] A_LOW_SMAX = 8'h04;
  localparam logic [7:0] A_RMAX = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_IST = 8'h10;
  localparam logic [7:0] A_ICLR = 8'h14;
  localparam logic [7:0] A_IEN = 8'h18;
  localparam logic [15:0] FS_RST = 16'h03e8;
  localparam logic [15:0] TOP_RST = 16'h2710;
  localparam logic [15:0] LOW_RST = 16'h0064;
  localparam logic [15:0] SMAX_RST = 16'h2710;
  localparam logic [3:0] RMAX_RST = 4'h5;

  typedef enum logic [2:0] {
    FN_FWD = 3'b001,
    FN_RFL = 3'b010,
    FN_SWR = 3'b100
  } fpm_func_e;

  typedef enum logic [2:0] {
    PW_OFF = 3'b001,
    PW_FLASH = 3'b010,
    PW_RUN = 3'b100
  } fpm_pwr_e;

  typedef struct packed {
    logic [14:0] pad;
    logic rerr;
    logic buzz;
    logic under;
    logic over;
    fpm_pwr_e pw;
    logic bl;
    logic [3:0] range;
    logic autos;
    logic logu;
    fpm_func_e func;
  } fpm_stat_s;

endpackage

// ==== shared/fpm_keys_if.sv ====
/*
  key press pulses and held levels between the key front end and core.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface fpm_keys_if
  import fpm_pkg::*;
();
  logic [KEY_N-1:0] held;
  logic [KEY_N-1:0] press;
  modport src (output held, output press);
  modport dst (input held, input press);
endinterface

// ==== core/fpm_keys.sv ====
/*
  key front end: synchronises raw key pins and makes press pulses.
  assumes keys are debounced outside and high while pressed.
*/
`timescale 1ns/1ps
module fpm_keys
  import fpm_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [KEY_N-1:0] key_raw,
  fpm_keys_if.src kif
);

  typedef struct packed {
    logic [KEY_N-1:0] s1;
    logic [KEY_N-1:0] s2;
    logic [KEY_N-1:0] prev;
    logic [KEY_N-1:0] press;
  } fpm_keys_s;

  fpm_keys_s r;
  fpm_keys_s n;

  always_comb begin
    n = r;
    n.s1 = key_raw;
    n.s2 = r.s1;
    n.prev = r.s2;
    n.press = r.s2 & ~r.prev;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign kif.held = r.s2;
  assign kif.press = r.press;

  AST_KEY_PULSE: assert property (@(posedge mclk) disable iff (!resetn)
    r.press[K_FWD] |=> !r.press[K_FWD] && r.prev[K_FWD])
    else $error("key press pulse longer than one cycle");

endmodule

// ==== core/fpm_front_panel.sv ====
/*
  front panel control of an rf power meter: key functions, range,
  limit symbols, buzzer, backlight and power state, ahb-lite registers.
  assumes readings arrive on mclk in tenths; key pins are asynchronous.
*/
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module fpm_front_panel
  import fpm_pkg::*;
#(
  parameter longint BL_OFF_CYCLES = BL_CYC,
  parameter longint FLASH_CYCLES = FLASH_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [KEY_N-1:0] key_raw,
  input wire logic [15:0] fwd_pwr,
  input wire logic [15:0] rfl_pwr,
  input wire logic [15:0] fwd_dbm,
  input wire logic [15:0] rfl_dbm,
  input wire logic [15:0] swr_val,
  input wire logic [15:0] rl_val,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [15:0] disp_val,
  output logic [IND_W-1:0] disp_ind,
  output logic disp_flash,
  output logic sym_over,
  output logic sym_under,
  output logic backlight,
  output logic meter_on,
  output logic buzzer,
  output logic irq
);

  typedef struct packed {
    fpm_pwr_e pw;
    logic [31:0] fcnt;
    fpm_func_e func;
    logic logu;
    logic autos;
    logic [3:0] range;
    logic [15:0] mn;
    logic [15:0] mx;
    logic mmv;
    logic hold_min;
    logic hold_max;
    logic bl;
    logic [37:0] bcnt;
    logic [15:0] disp;
    logic [IND_W-1:0] ind;
    logic over;
    logic under;
    logic buzz;
    logic rerr;
    logic [15:0] fs;
    logic [15:0] top;
    logic [15:0] low;
    logic [15:0] smax;
    logic [3:0] rmax;
    logic [EV_N-1:0] ist;
    logic [EV_N-1:0] ien;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } fpm_state_s;

  fpm_state_s r;
  fpm_state_s n;
  logic [KEY_N-1:0] pk;
  logic [KEY_N-1:0] hk;
  logic run;
  logic new_sel;
  logic [15:0] live;
  logic [15:0] pw_in;
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] clr;
  logic [31:0] rd;
  fpm_stat_s st;

  fpm_keys_if kif ();

  fpm_keys u_keys (
    .mclk(mclk),
    .resetn(resetn),
    .key_raw(key_raw),
    .kif(kif)
  );

  // true when a*ka exceeds b*kb
  function automatic logic gt(input logic [15:0] a, input logic [11:0] ka,
                              input logic [15:0] b, input logic [11:0] kb);
    logic [27:0] x;
    logic [27:0] y;
    x = a * ka;
    y = b * kb;
    return x > y;
  endfunction

  assign pk = kif.press;
  assign hk = kif.held;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    live = '0;
    pw_in = '0;
    ev = '0;
    clr = '0;
    rd = '0;
    st = '0;
    // power state
    case (r.pw)
      PW_OFF: begin
        if (pk[K_PWR]) begin
          n.pw = PW_FLASH;
          n.fcnt = '0;
        end
      end
      PW_FLASH: begin
        n.fcnt = r.fcnt + 32'h1;
        if (r.fcnt >= 32'(FLASH_CYCLES - 1)) begin
          n.pw = PW_RUN;
        end
        if (pk[K_PWR]) begin
          n.pw = PW_OFF;
        end
      end
      PW_RUN: begin
        if (pk[K_PWR]) begin
          n.pw = PW_OFF;
        end
      end
      default: begin
        n.pw = PW_OFF;
      end
    endcase
    if (!hk[K_MASTER]) begin
      n.pw = PW_OFF;
    end
    run = r.pw == PW_RUN;
    new_sel = run && (pk[K_FWD] || pk[K_RFL] || pk[K_SWR] || pk[K_LOG]);
    // function keys
    if (run) begin
      if (pk[K_FWD]) begin
        n.func = FN_FWD;
        n.logu = 1'b0;
      end else if (pk[K_RFL]) begin
        n.func = FN_RFL;
        n.logu = 1'b0;
      end else if (pk[K_SWR]) begin
        n.func = FN_SWR;
        n.logu = 1'b0;
      end else if (pk[K_LOG]) begin
        n.logu = 1'b1;
      end
      if (pk[K_AUTO]) begin
        n.autos = 1'b1;
      end
      if (pk[K_UP]) begin
        n.autos = 1'b0;
        if (r.range != 4'hf) begin
          n.range = r.range + 4'h1;
        end
      end else if (pk[K_DOWN]) begin
        n.autos = 1'b0;
        if (r.range != 4'h0) begin
          n.range = r.range - 4'h1;
        end
      end else if (r.autos && !pk[K_AUTO]) begin
        // automatic ranging: above full scale up, below a tenth down
        if (gt(fwd_pwr, K_ONE_PC, r.fs, K_ONE_PC) && r.range < r.rmax) begin
          n.range = r.range + 4'h1;
        end else if (gt(r.fs, K_ONE_PC, fwd_pwr, K_ONE_PM)
                     && r.range != 4'h0) begin
          n.range = r.range - 4'h1;
        end
      end
    end
    // backlight and its timeout
    if (r.bl) begin
      n.bcnt = r.bcnt + 38'h1;
      if (r.bcnt >= 38'(BL_OFF_CYCLES - 1)) begin
        n.bl = 1'b0;
      end
    end
    if (run && pk[K_LIGHT]) begin
      n.bl = ~r.bl;
      n.bcnt = '0;
    end
    if (n.pw == PW_OFF) begin
      n.bl = 1'b0;
    end
    // live value of the selected function
    pw_in = (n.func == FN_RFL) ? rfl_pwr : fwd_pwr;
    case (n.func)
      FN_FWD: live = n.logu ? fwd_dbm : fwd_pwr;
      FN_RFL: live = n.logu ? rfl_dbm : rfl_pwr;
      FN_SWR: begin
        if (n.logu) begin
          live = rl_val;
        end else if (swr_val < SWR_LO) begin
          live = SWR_LO;
        end else if (swr_val > SWR_HI) begin
          live = SWR_HI;
        end else begin
          live = swr_val;
        end
      end
      default: live = '0;
    endcase
    // min and max trackers
    if (new_sel) begin
      n.mmv = 1'b0;
    end else if (run) begin
      n.mmv = 1'b1;
      if (!r.mmv || live < r.mn) begin
        n.mn = live;
      end
      if (!r.mmv || live > r.mx) begin
        n.mx = live;
      end
    end
    n.hold_min = run && hk[K_MIN];
    n.hold_max = run && hk[K_MAX] && !hk[K_MIN];
    if (n.hold_max) begin
      n.disp = n.mx;
    end else if (n.hold_min) begin
      n.disp = n.mn;
    end else begin
      n.disp = live;
    end
    // limit symbols
    n.over = 1'b0;
    n.under = 1'b0;
    if (n.pw != PW_OFF) begin
      if (n.func != FN_SWR && !n.logu) begin
        n.over = gt(pw_in, K_ONE_PM, r.fs, K_FS_OVER)
                 || gt(pw_in, K_ONE_PC, r.top, K_120);
      end else if (n.func != FN_SWR) begin
        n.over = gt(pw_in, K_ONE_PC, r.fs, K_120);
        n.under = gt(r.low, K_3, pw_in, K_ONE_PC);
      end else if (!n.logu) begin
        n.under = gt(r.low, K_20, fwd_pwr, K_ONE_PC);
        n.over = fwd_pwr == rfl_pwr;
      end else begin
        n.under = gt(r.low, K_20, fwd_pwr, K_ONE_PC)
                  || gt(r.low, K_20, rfl_pwr, K_ONE_PC)
                  || rl_val > RL_MAX;
      end
      if (n.over) begin
        n.under = 1'b0;
      end
    end
    n.rerr = (n.pw != PW_OFF) && (n.range > r.rmax);
    n.buzz = (n.pw != PW_OFF) && gt(fwd_pwr, K_ONE_PC, r.smax, K_120);
    // indicators
    n.ind = '0;
    if (n.pw != PW_OFF) begin
      n.ind[I_FWD] = n.func == FN_FWD;
      n.ind[I_RFL] = n.func == FN_RFL;
      n.ind[I_SWR] = n.func == FN_SWR && !n.logu;
      n.ind[I_DBM] = n.func != FN_SWR && n.logu;
      n.ind[I_WATT] = n.func != FN_SWR && !n.logu;
      n.ind[I_RL] = n.func == FN_SWR && n.logu;
      n.ind[I_AUTO] = n.autos;
      n.ind[I_RERR] = n.rerr;
    end
    // events and interrupt status, set wins over clear
    ev[E_OVER] = n.over && !r.over;
    ev[E_UNDER] = n.under && !r.under;
    ev[E_BUZZ] = n.buzz && !r.buzz;
    ev[E_RERR] = n.rerr && !r.rerr;
    if (r.a_wr && r.a_addr == A_ICLR) begin
      clr = hwdata[EV_N-1:0];
    end
    n.ist = (r.ist & ~clr) | ev;
    // bus data phase writes
    if (r.a_wr) begin
      if (r.a_addr == A_FS_TOP) begin
        n.fs = hwdata[15:0];
        n.top = hwdata[31:16];
      end else if (r.a_addr == A_LOW_SMAX) begin
        n.low = hwdata[15:0];
        n.smax = hwdata[31:16];
      end else if (r.a_addr == A_RMAX) begin
        n.rmax = hwdata[3:0];
      end else if (r.a_addr == A_IEN) begin
        n.ien = hwdata[EV_N-1:0];
      end
    end
    // bus address phase and read data
    st.func = r.func;
    st.logu = r.logu;
    st.autos = r.autos;
    st.range = r.range;
    st.bl = r.bl;
    st.pw = r.pw;
    st.over = r.over;
    st.under = r.under;
    st.buzz = r.buzz;
    st.rerr = r.rerr;
    if (haddr[7:0] == A_FS_TOP) begin
      rd = {r.top, r.fs};
    end else if (haddr[7:0] == A_LOW_SMAX) begin
      rd = {r.smax, r.low};
    end else if (haddr[7:0] == A_RMAX) begin
      rd = {28'h0, r.rmax};
    end else if (haddr[7:0] == A_STAT) begin
      rd = st;
    end else if (haddr[7:0] == A_IST) begin
      rd = {28'h0, r.ist};
    end else if (haddr[7:0] == A_IEN) begin
      rd = {28'h0, r.ien};
    end
    n.a_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      n.a_wr = hwrite;
      n.a_addr = haddr[7:0];
      n.rdata = hwrite ? 32'h0 : rd;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.pw <= PW_OFF;
      r.func <= FN_FWD;
      r.fs <= FS_RST;
      r.top <= TOP_RST;
      r.low <= LOW_RST;
      r.smax <= SMAX_RST;
      r.rmax <= RMAX_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hrdata = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign disp_val = r.disp;
  assign disp_ind = r.ind;
  assign disp_flash = r.pw == PW_FLASH;
  assign sym_over = r.over;
  assign sym_under = r.under;
  assign backlight = r.bl;
  assign meter_on = r.pw != PW_OFF;
  assign buzzer = r.buzz;
  assign irq = |(r.ist & r.ien);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_FWD_SEL: assert property (
    run && hk[K_MASTER] && pk[K_FWD] && !pk[K_PWR]
    |=> r.func == FN_FWD && r.ind[I_FWD] && r.ind[I_WATT] && !r.mmv)
    else $error("forward key did not select forward power");

  AST_SWR_CLAMP: assert property (
    r.pw == PW_RUN && r.func == FN_SWR && !r.logu && !r.hold_min
    && !r.hold_max |-> r.disp >= SWR_LO && r.disp <= SWR_HI)
    else $error("ratio display outside 1.0 to 199.9");

  AST_MAX_HOLD: assert property (
    run && hk[K_MASTER] && hk[K_MAX] && !hk[K_MIN] && !pk[K_PWR]
    |=> r.hold_max && r.disp == r.mx)
    else $error("max key does not show maximum");

  AST_RL_SEL: assert property (
    run && hk[K_MASTER] && r.func == FN_SWR && pk[K_LOG] && !pk[K_PWR]
    && !pk[K_FWD] && !pk[K_RFL] && !pk[K_SWR]
    |=> r.ind[I_RL] && !r.ind[I_SWR] && r.disp == $past(rl_val)
        || r.hold_min || r.hold_max)
    else $error("log key in ratio mode did not show return loss");

  AST_BL_TIMEOUT: assert property (
    r.bl && r.bcnt == 38'(BL_OFF_CYCLES - 1) && !pk[K_LIGHT] |=> !r.bl)
    else $error("backlight did not time out");

  AST_AUTO_STOP: assert property (
    run && hk[K_MASTER] && r.autos && pk[K_UP] && !pk[K_PWR]
    |=> !r.autos && !r.ind[I_AUTO] && r.range == $past(r.range) + 4'h1
        || $past(r.range) == 4'hf)
    else $error("up key did not leave automatic scaling");

  AST_MASTER_OFF: assert property (
    !hk[K_MASTER] |=> r.pw == PW_OFF ##1 !meter_on)
    else $error("meter on while master switch off");

  AST_FLASH: assert property (
    r.pw == PW_OFF && pk[K_PWR] && hk[K_MASTER]
    |=> disp_flash ##1 (r.fcnt == 32'h1 || !hk[K_MASTER] || r.pw == PW_OFF))
    else $error("no display flash after switch on");

  AST_SWR_OVER: assert property (
    run && hk[K_MASTER] && !pk[K_PWR] && pk == $past(pk) && pk == '0
    && r.func == FN_SWR && !r.logu && fwd_pwr == rfl_pwr
    |=> sym_over && !sym_under)
    else $error("equal forward and reflected not flagged over-range");

  AST_BUZZ: assert property (
    meter_on && hk[K_MASTER] && !pk[K_PWR]
    && gt(fwd_pwr, K_ONE_PC, r.smax, K_120) |=> buzzer)
    else $error("buzzer silent above sensor limit");

  AST_IRQ_SET: assert property (
    ev[E_OVER] |=> r.ist[E_OVER])
    else $error("over-range event lost");

endmodule

// ==== verification/fpm_panel_model.sv ====
/*
  operator side of the front panel: push buttons and the buzzer listener.
  assumes keys are debounced, high while pressed, sampled on mclk.
*/
`timescale 1ns/1ps
module fpm_panel_model
  import fpm_pkg::*;
(
  input wire logic mclk,
  input wire logic buzzer,
  output logic [KEY_N-1:0] key_raw
);
  int beeps = 0;
  logic buz_q = 1'b0;

  initial key_raw = '0;

  //////////////////////////////////////////////////////////////////////////
  // counts buzzer onsets as the operator would hear them
  always @(posedge mclk) begin
    if (buzzer === 1'b1 && buz_q !== 1'b1) begin
      beeps++;
    end
    buz_q <= buzzer;
  end

  //////////////////////////////////////////////////////////////////////////
  // a key level is held long enough for the synchroniser to see it
  task automatic lvl(input int k, input logic v);
    @(posedge mclk);
    key_raw[k] <= v;
    repeat (6) @(posedge mclk);
  endtask

  task automatic tap(input int k);
    lvl(k, 1'b1);
    lvl(k, 1'b0);
  endtask
endmodule

// ==== verification/tb_top.sv ====
/*
  self-checking bench of the front panel control block.
  assumes shortened backlight and flash counts and an ahb-lite master.
*/
`timescale 1ns/1ps
module tb_top
  import fpm_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  wire logic [KEY_N-1:0] key_raw;
  logic [15:0] fwd_pwr = '0, rfl_pwr = '0, swr_val = 16'h0014;
  logic [15:0] rl_val = 16'h00c8, fwd_dbm = 16'h0123, rfl_dbm = 16'h0234;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, disp_flash, sym_over, sym_under;
  logic backlight, meter_on, buzzer, irq;
  logic [15:0] disp_val;
  logic [IND_W-1:0] disp_ind;
  int err_total = 0, samples_checked = 0, n_flash = 0, rg = 0, v;
  int mx, mn;
  int q[$];

  always #5 mclk = ~mclk;

  always @(posedge mclk) if (disp_flash === 1'b1) n_flash++;

  fpm_front_panel #(.BL_OFF_CYCLES(50), .FLASH_CYCLES(20)) fpm_front_panel_i (
    .mclk(mclk), .resetn(resetn), .key_raw(key_raw), .fwd_pwr(fwd_pwr),
    .rfl_pwr(rfl_pwr), .fwd_dbm(fwd_dbm), .rfl_dbm(rfl_dbm),
    .swr_val(swr_val), .rl_val(rl_val), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .disp_val(disp_val), .disp_ind(disp_ind),
    .disp_flash(disp_flash), .sym_over(sym_over), .sym_under(sym_under),
    .backlight(backlight), .meter_on(meter_on), .buzzer(buzzer), .irq(irq));

  fpm_panel_model fpm_panel_model_i (
    .mclk(mclk), .buzzer(buzzer), .key_raw(key_raw));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, '0);
    chk(rd, exp);
    chk(hresp, 1'b0);
  endtask

  task automatic meas(input int f, input int r, input int s, input int l);
    @(posedge mclk);
    fwd_pwr <= 16'(f);
    rfl_pwr <= 16'(r);
    swr_val <= 16'(s);
    rl_val <= 16'(l);
    repeat (4) @(posedge mclk);
  endtask

  task automatic sym(input logic o, input logic u);
    chk({30'h0, sym_over, sym_under}, {30'h0, o, u});
  endtask

  task automatic tap(input int k);
    fpm_panel_model_i.tap(k);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    v = $urandom(7);
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rdchk(A_STAT, 32'h0000_0401);
    rdchk(A_FS_TOP, {TOP_RST, FS_RST});
    rdchk(A_LOW_SMAX, {SMAX_RST, LOW_RST});
    rdchk(A_RMAX, {28'h0, RMAX_RST});
    rdchk(A_IEN, '0);
    rdchk(8'h1c, '0);
    bus(1'b1, A_STAT, '1);
    rdchk(A_STAT, 32'h0000_0401);
    $display("test registers finished");
    tap(K_PWR);
    chk(meter_on, 1'b0);
    fpm_panel_model_i.lvl(K_MASTER, 1'b1);
    tap(K_PWR);
    repeat (30) @(posedge mclk);
    chk(n_flash >= 19 && n_flash <= 21, 1'b1);
    chk({disp_flash, meter_on}, 2'b01);
    $display("test power finished");
    tap(K_RFL);
    chk(disp_ind, 8'h12);
    tap(K_FWD);
    chk(disp_ind, 8'h11);
    bus(1'b1, A_IEN, 32'h1);
    meas(20000, 0, 20, 200);
    sym(1'b1, 1'b0);
    chk({buzzer, irq}, 2'b11);
    rdchk(A_IST, 32'h5);
    bus(1'b1, A_ICLR, 32'h5);
    // the clear lands at the edge that ends the data phase
    @(posedge mclk);
    chk(irq, 1'b0);
    rdchk(A_IST, 32'h0);
    meas(0, 0, 20, 200);
    sym(1'b0, 1'b0);
    bus(1'b1, A_IEN, 32'h0);
    meas(20000, 0, 20, 200);
    chk(irq, 1'b0);
    rdchk(A_IST, 32'h5);
    bus(1'b1, A_ICLR, 32'h5);
    meas(12000, 0, 20, 200);
    chk(buzzer, 1'b0);
    meas(12001, 0, 20, 200);
    chk(buzzer, 1'b1);
    chk(fpm_panel_model_i.beeps, 3);
    $display("test power limits finished");
    tap(K_LOG);
    chk(disp_ind & 8'h18, 8'h08);
    chk(disp_val, fwd_dbm);
    meas(1201, 0, 20, 200);
    sym(1'b1, 1'b0);
    meas(1200, 0, 20, 200);
    sym(1'b0, 1'b0);
    meas(2, 0, 20, 200);
    sym(1'b0, 1'b1);
    meas(3, 0, 20, 200);
    sym(1'b0, 1'b0);
    $display("test dbm finished");
    tap(K_SWR);
    chk(disp_ind & 8'h0f, 8'h04);
    meas(500, 100, 5000, 200);
    chk(disp_val, 16'h07cf);
    sym(1'b0, 1'b0);
    meas(500, 100, 3, 200);
    chk(disp_val, 16'h000a);
    meas(19, 5, 25, 200);
    chk(disp_val, 16'h0019);
    sym(1'b0, 1'b1);
    meas(500, 500, 25, 200);
    sym(1'b1, 1'b0);
    tap(K_LOG);
    chk(disp_ind[I_RL], 1'b1);
    chk(disp_val, 16'h00c8);
    meas(500, 19, 25, 200);
    sym(1'b0, 1'b1);
    meas(500, 100, 25, 401);
    sym(1'b0, 1'b1);
    meas(500, 100, 25, 400);
    sym(1'b0, 1'b0);
    $display("test ratio finished");
    v = 100 + $urandom % 900;
    q.push_back(v);
    meas(v, 0, 25, 400);
    tap(K_FWD);
    for (int i = 0; i < 5; i++) begin
      v = 100 + $urandom % 900;
      q.push_back(v);
      meas(v, 0, 25, 400);
    end
    mx = q[0];
    mn = q[0];
    foreach (q[i]) begin
      if (q[i] > mx) mx = q[i];
      if (q[i] < mn) mn = q[i];
    end
    fpm_panel_model_i.lvl(K_MAX, 1'b1);
    chk(disp_val, mx);
    fpm_panel_model_i.lvl(K_MAX, 1'b0);
    chk(disp_val, v);
    fpm_panel_model_i.lvl(K_MIN, 1'b1);
    chk(disp_val, mn);
    fpm_panel_model_i.lvl(K_MIN, 1'b0);
    chk(disp_val, v);
    $display("test min max finished");
    tap(K_LIGHT);
    chk(backlight, 1'b1);
    tap(K_LIGHT);
    chk(backlight, 1'b0);
    tap(K_LIGHT);
    chk(backlight, 1'b1);
    repeat (45) @(posedge mclk);
    chk(backlight, 1'b0);
    $display("test backlight finished");
    meas(500, 0, 25, 400);
    bus(1'b1, A_IEN, 32'h8);
    tap(K_AUTO);
    chk(disp_ind[I_AUTO], 1'b1);
    for (int i = 0; i < 6; i++) begin
      tap(K_UP);
      rg++;
      chk(disp_ind[I_AUTO], 1'b0);
      chk(disp_ind[I_RERR], rg > RMAX_RST);
      bus(1'b0, A_STAT, '0);
      chk(rd[8:5], rg[3:0]);
    end
    chk(irq, 1'b1);
    bus(1'b1, A_ICLR, 32'h8);
    @(posedge mclk);
    chk(irq, 1'b0);
    tap(K_DOWN);
    chk(disp_ind[I_RERR], 1'b0);
    bus(1'b0, A_STAT, '0);
    chk(rd[8:5], 4'(rg - 1));
    $display("test scale finished");
    stop_test();
  end
endmodule
